// File: core/bgce_pkg.sv
`default_nettype none
package bgce_pkg;

	// configuration dword offsets (byte addresses)
	localparam logic [7:0] OFF_GPIO = 8'h64;
	localparam logic [7:0] OFF_CLK_STAT = 8'h68;

	// pin and clock counts
	localparam int GPIO_PINS = 4;
	localparam int SEC_CLOCKS = 10;
	localparam int PAIR_CLOCKS = 4;
	localparam int ERR_CAUSES = 8;

	// general pin register field positions
	localparam int POS_OUT_CLR = 8;
	localparam int POS_OUT_SET = 12;
	localparam int POS_OE_CLR = 16;
	localparam int POS_OE_SET = 20;
	localparam int POS_GPIO_RSVD = 24;
	localparam int POS_GPIO_IN = 28;

	// clock gating and status field positions
	localparam int POS_SINGLE_DIS = 8;
	localparam int POS_CLK_RSVD = 14;
	localparam int POS_ERR_STAT = 16;
	localparam int CLK_FIELD_W = 14;

	// error cause indices within the status field
	localparam int ERR_ADDR_PARITY = 0;
	localparam int ERR_PW_PARITY = 1;
	localparam int ERR_PW_NODELIVER = 2;
	localparam int ERR_PW_TABORT = 3;
	localparam int ERR_PW_MABORT = 4;
	localparam int ERR_DW_NODELIVER = 5;
	localparam int ERR_DR_NODATA = 6;
	localparam int ERR_DT_MTIMEOUT = 7;

	// reset values
	localparam logic [3:0] RST_GPIO_FIELD = 4'h0;
	localparam logic [CLK_FIELD_W-1:0] RST_CLK_DIS = 14'h0000;
	localparam logic [7:0] RST_ERR_STAT = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage
`default_nettype wire

// File: core/bgce_sclk_if.sv
`default_nettype none
interface bgce_sclk_if #(
	parameter int CLOCKS = 10
);
	logic [CLOCKS-1:0] run;

	modport ctrl (output run);
	modport gen (input run);
endinterface
`default_nettype wire

// File: core/bgce_sclk_gen.sv
`default_nettype none
module bgce_sclk_gen
	import bgce_pkg::*;
#(
	parameter int CLOCKS = SEC_CLOCKS
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	bgce_sclk_if.gen sclk,
	output logic [CLOCKS-1:0] o_secondary_clock_outputs
);

	// each output is the bus clock halved; a stopped output is held low
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_secondary_clock_outputs <= '0;
		end else begin
			o_secondary_clock_outputs <= ~o_secondary_clock_outputs & sclk.run;
		end
	end

endmodule
`default_nettype wire

// File: core/bgce_regs.sv
`default_nettype none
// Function
// - write one to output-clear bit drives bidirectional pin low
// - write one to output-set bit drives bidirectional pin high
// - input-only pins are never driven by set or clear writes
// - zero writes do nothing; set/clear fields read last written, reset zero
// - write one to enable-clear bit makes pin input only, driver off
// - write one to enable-set bit makes pin bidirectional, drives data
// - zero writes to enable fields do nothing; read last written, reset zero
// - reserved bits 27:24 always read zero
// - input field shows pin levels, refreshed on the second clock after change
// - clocks 0-3 stop only when both disable bits are one
// - clocks 4-9 stop and stay low when their disable bit is one
// - reserved clock-gating bits 15:14 read zero
// - bit 16 records address parity error; resets zero, write one clears
// - bit 17 records posted write data parity error on target bus
// - bit 18 records posted write non-delivery after many attempts
// - bit 19 records target abort delivering posted write data
// - bit 20 records master abort delivering posted write data
// - bit 21 records delayed write non-delivery after many attempts
// - bit 22 records delayed read with no data after many attempts
// - bit 23 records delayed transaction master timeout
// - cleared disable bit plus enable lets error assert; set bit suppresses
module bgce_regs
	import bgce_pkg::*;
#(
	parameter int PINS = GPIO_PINS
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [3:0] i_cfg_byte_en,
	input wire logic [31:0] i_cfg_wdata,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_rd_valid,
	input wire logic [PINS-1:0] i_gpio_in,
	output logic [PINS-1:0] o_gpio_out,
	output logic [PINS-1:0] o_gpio_oe,
	output logic [SEC_CLOCKS-1:0] o_secondary_clock_outputs,
	input wire logic [ERR_CAUSES-1:0] i_err_event,
	input wire logic [ERR_CAUSES-1:0] i_event_disable,
	input wire logic i_system_error_enable_bit,
	output logic o_primary_system_error_n
);

	// dword address match, low two address bits ignored
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
		addr_hit = (addr[7:2] == offset[7:2]);
	endfunction

	// four-bit field from a written dword
	function automatic logic [3:0] nib(input logic [31:0] data, input int pos);
		nib = data[pos +: 4];
	endfunction

	// byte lane enable covering a bit position
	function automatic logic lane(input logic [3:0] be, input int pos);
		lane = be[pos / 8];
	endfunction

	logic [PINS-1:0] gpio_meta;
	logic [PINS-1:0] gpio_sync;
	logic [3:0] out_clr_field;
	logic [3:0] out_set_field;
	logic [3:0] oe_clr_field;
	logic [3:0] oe_set_field;
	logic [CLK_FIELD_W-1:0] clk_dis;
	logic [POS_SINGLE_DIS-1:0] clk_pair_dis;
	logic [CLK_FIELD_W-POS_SINGLE_DIS-1:0] clk_single_dis;
	logic [ERR_CAUSES-1:0] err_stat;
	logic gpio_sel;
	logic clk_stat_sel;
	logic wr_gpio;
	logic wr_clk_stat;
	logic out_lane;
	logic oe_lane;
	logic [PINS-1:0] set_req;
	logic [PINS-1:0] clr_req;
	logic [PINS-1:0] oe_set_req;
	logic [PINS-1:0] oe_clr_req;
	logic [PINS-1:0] next_gpio_out;
	logic [PINS-1:0] next_gpio_oe;
	logic [ERR_CAUSES-1:0] err_fire;
	logic [ERR_CAUSES-1:0] err_w1c;
	logic [ERR_CAUSES-1:0] next_err_stat;
	logic [SEC_CLOCKS-1:0] clk_run;
	logic [31:0] next_rdata;

	bgce_sclk_if #(.CLOCKS(SEC_CLOCKS)) sclk ();

	// dword decode, shared by reads and writes
	assign gpio_sel = addr_hit(i_cfg_addr, OFF_GPIO);
	assign clk_stat_sel = addr_hit(i_cfg_addr, OFF_CLK_STAT);
	assign wr_gpio = i_cfg_wr && gpio_sel;
	assign wr_clk_stat = i_cfg_wr && clk_stat_sel;
	assign out_lane = lane(i_cfg_byte_en, POS_OUT_CLR);
	assign oe_lane = lane(i_cfg_byte_en, POS_OE_CLR);

	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			gpio_meta <= '0;
		end else begin
			gpio_meta <= i_gpio_in;
		end
	end

	// second stage, the only reader of the first
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			gpio_sync <= '0;
		end else begin
			gpio_sync <= gpio_meta;
		end
	end

	// one bits written this cycle into the output-set/clear fields
	always_comb begin
		set_req = '0;
		clr_req = '0;
		if (wr_gpio && out_lane) begin
			set_req = nib(i_cfg_wdata, POS_OUT_SET);
			clr_req = nib(i_cfg_wdata, POS_OUT_CLR);
		end
	end

	// one bits written this cycle into the enable-set/clear fields
	always_comb begin
		oe_set_req = '0;
		oe_clr_req = '0;
		if (wr_gpio && oe_lane) begin
			oe_set_req = nib(i_cfg_wdata, POS_OE_SET);
			oe_clr_req = nib(i_cfg_wdata, POS_OE_CLR);
		end
	end

	// output-clear field keeps the last written value
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			out_clr_field <= RST_GPIO_FIELD;
		end else if (wr_gpio && out_lane) begin
			out_clr_field <= nib(i_cfg_wdata, POS_OUT_CLR);
		end
	end

	// output-set field keeps the last written value
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			out_set_field <= RST_GPIO_FIELD;
		end else if (wr_gpio && out_lane) begin
			out_set_field <= nib(i_cfg_wdata, POS_OUT_SET);
		end
	end

	// enable-clear field keeps the last written value
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			oe_clr_field <= RST_GPIO_FIELD;
		end else if (wr_gpio && oe_lane) begin
			oe_clr_field <= nib(i_cfg_wdata, POS_OE_CLR);
		end
	end

	// enable-set field keeps the last written value
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			oe_set_field <= RST_GPIO_FIELD;
		end else if (wr_gpio && oe_lane) begin
			oe_set_field <= nib(i_cfg_wdata, POS_OE_SET);
		end
	end

	// output data: ones set or clear, zeros leave the bit alone
	always_comb begin
		next_gpio_out = o_gpio_out;
		next_gpio_out = next_gpio_out | set_req;
		// clear drives low, clear wins a same-write clash
		next_gpio_out = next_gpio_out & ~clr_req;
	end

	// direction: enable-set makes a pin bidirectional, enable-clear input only
	always_comb begin
		next_gpio_oe = o_gpio_oe;
		next_gpio_oe = next_gpio_oe | oe_set_req;
		// tristate driver, clear wins a same-write clash
		next_gpio_oe = next_gpio_oe & ~oe_clr_req;
	end

	// pin level follows one cycle after the write
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_gpio_out <= RST_GPIO_FIELD;
		end else begin
			o_gpio_out <= next_gpio_out;
		end
	end

	// pins with the driver off stay undriven whatever data holds
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_gpio_oe <= RST_GPIO_FIELD;
		end else begin
			o_gpio_oe <= next_gpio_oe;
		end
	end

	// clock gating pairs for clocks 0 to 3, byte lane 0
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			clk_pair_dis <= RST_CLK_DIS[POS_SINGLE_DIS-1:0];
		end else if (wr_clk_stat && i_cfg_byte_en[0]) begin
			clk_pair_dis <= i_cfg_wdata[POS_SINGLE_DIS-1:0];
		end
	end

	// clock gating single bits for clocks 4 to 9, byte lane 1
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			clk_single_dis <= RST_CLK_DIS[CLK_FIELD_W-1:POS_SINGLE_DIS];
		end else if (wr_clk_stat && i_cfg_byte_en[1]) begin
			clk_single_dis <= i_cfg_wdata[CLK_FIELD_W-1:POS_SINGLE_DIS];
		end
	end

	assign clk_dis = {clk_single_dis, clk_pair_dis};

	// run enables per secondary clock
	always_comb begin
		clk_run = '0;
		for (int i = 0; i < PAIR_CLOCKS; i++) begin
			clk_run[i] = ~(clk_dis[2*i] & clk_dis[2*i+1]);
		end
		for (int i = PAIR_CLOCKS; i < SEC_CLOCKS; i++) begin
			clk_run[i] = ~clk_dis[POS_SINGLE_DIS + i - PAIR_CLOCKS];
		end
	end

	assign sclk.run = clk_run;

	bgce_sclk_gen #(.CLOCKS(SEC_CLOCKS)) u_sclk_gen (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.sclk(sclk),
		.o_secondary_clock_outputs(o_secondary_clock_outputs)
	);

	// an event fires only when enabled and not disabled
	assign err_fire = i_err_event & ~i_event_disable & {ERR_CAUSES{i_system_error_enable_bit}};

	// one bits written to the status byte clear matching flags
	assign err_w1c = (wr_clk_stat && i_cfg_byte_en[2]) ? i_cfg_wdata[POS_ERR_STAT +: ERR_CAUSES]
		: '0;

	always_comb begin
		next_err_stat = err_stat & ~err_w1c;
		next_err_stat[ERR_ADDR_PARITY] = next_err_stat[ERR_ADDR_PARITY] | err_fire[ERR_ADDR_PARITY];
		next_err_stat[ERR_PW_PARITY] = next_err_stat[ERR_PW_PARITY] | err_fire[ERR_PW_PARITY];
		next_err_stat[ERR_PW_NODELIVER] = next_err_stat[ERR_PW_NODELIVER]
			| err_fire[ERR_PW_NODELIVER];
		next_err_stat[ERR_PW_TABORT] = next_err_stat[ERR_PW_TABORT] | err_fire[ERR_PW_TABORT];
		next_err_stat[ERR_PW_MABORT] = next_err_stat[ERR_PW_MABORT] | err_fire[ERR_PW_MABORT];
		next_err_stat[ERR_DW_NODELIVER] = next_err_stat[ERR_DW_NODELIVER]
			| err_fire[ERR_DW_NODELIVER];
		next_err_stat[ERR_DR_NODATA] = next_err_stat[ERR_DR_NODATA] | err_fire[ERR_DR_NODATA];
		next_err_stat[ERR_DT_MTIMEOUT] = next_err_stat[ERR_DT_MTIMEOUT]
			| err_fire[ERR_DT_MTIMEOUT];
	end

	// flags set on the same edge as the error output, sticky until cleared
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			err_stat <= RST_ERR_STAT;
		end else begin
			err_stat <= next_err_stat;
		end
	end

	// error output low in the cycle after any event fires, once for events firing together
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_primary_system_error_n <= 1'b1;
		end else begin
			o_primary_system_error_n <= ~(|err_fire);
		end
	end

	// read data assembly
	always_comb begin
		next_rdata = RST_RDATA;
		if (gpio_sel) begin
			next_rdata[POS_OUT_CLR +: 4] = out_clr_field;
			next_rdata[POS_OUT_SET +: 4] = out_set_field;
			next_rdata[POS_OE_CLR +: 4] = oe_clr_field;
			next_rdata[POS_OE_SET +: 4] = oe_set_field;
			next_rdata[POS_GPIO_RSVD +: 4] = 4'h0;
			next_rdata[POS_GPIO_IN +: 4] = gpio_sync;
		end else if (clk_stat_sel) begin
			next_rdata[CLK_FIELD_W-1:0] = clk_dis;
			next_rdata[POS_CLK_RSVD +: 2] = 2'h0;
			next_rdata[POS_ERR_STAT +: ERR_CAUSES] = err_stat;
		end
	end

	// read answer strobe one cycle after the request
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_cfg_rd_valid <= 1'b0;
		end else begin
			o_cfg_rd_valid <= i_cfg_rd;
		end
	end

	// read data captured with the request; unmapped dwords read zero
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			o_cfg_rdata <= RST_RDATA;
		end else if (i_cfg_rd) begin
			o_cfg_rdata <= next_rdata;
		end
	end

endmodule
`default_nettype wire

// File: sim/bgce_regs_asserts.sv
`default_nettype none
module bgce_regs_asserts
	import bgce_pkg::*;
#(
	parameter int PINS = GPIO_PINS
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [3:0] i_cfg_byte_en,
	input wire logic [31:0] i_cfg_wdata,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_rd_valid,
	input wire logic [PINS-1:0] o_gpio_out,
	input wire logic [PINS-1:0] o_gpio_oe,
	input wire logic [SEC_CLOCKS-1:0] o_secondary_clock_outputs,
	input wire logic [ERR_CAUSES-1:0] i_err_event,
	input wire logic [ERR_CAUSES-1:0] i_event_disable,
	input wire logic i_system_error_enable_bit,
	input wire logic o_primary_system_error_n
);
	logic gw, gr, cr, cw, err;
	assign gw = i_cfg_wr && i_cfg_addr[7:2] == OFF_GPIO[7:2];
	assign gr = i_cfg_rd && i_cfg_addr[7:2] == OFF_GPIO[7:2];
	assign cr = i_cfg_rd && i_cfg_addr[7:2] == OFF_CLK_STAT[7:2];
	// write that stops every secondary clock
	assign cw = i_cfg_wr && i_cfg_addr[7:2] == OFF_CLK_STAT[7:2] && i_cfg_byte_en[1:0] == 2'b11
		&& i_cfg_wdata[13:0] == 14'h3fff;
	assign err = i_system_error_enable_bit && |(i_err_event & ~i_event_disable);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);
	property p_out; gw && i_cfg_byte_en[1] |=> o_gpio_out ==
		(($past(o_gpio_out) | $past(i_cfg_wdata[15:12])) & ~$past(i_cfg_wdata[11:8])); endproperty
	property p_oe; gw && i_cfg_byte_en[2] |=> o_gpio_oe ==
		(($past(o_gpio_oe) | $past(i_cfg_wdata[23:20])) & ~$past(i_cfg_wdata[19:16])); endproperty
	property p_hold; !gw |=> $stable(o_gpio_out) && $stable(o_gpio_oe); endproperty
	property p_rsv_pin; gr |=> o_cfg_rdata[27:24] == 4'h0; endproperty
	property p_rsv_clk; cr |=> o_cfg_rdata[31:24] == 8'h00 && o_cfg_rdata[15:14] == 2'b00; endproperty
	property p_stop; cw |=> ##1 (o_secondary_clock_outputs == 10'h000) [*3]; endproperty
	property p_err_on; err |=> !o_primary_system_error_n; endproperty
	property p_err_off; !err |=> o_primary_system_error_n; endproperty
	property p_rdv; i_cfg_rd |=> o_cfg_rd_valid; endproperty
	a_out: assert property (p_out) else $error("pin data wrong");
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	a_hold: assert property (p_hold) else $error("pin state moved");
	a_rsv_pin: assert property (p_rsv_pin) else $error("pin reserved nonzero");
	a_rsv_clk: assert property (p_rsv_clk) else $error("clock reserved nonzero");
	a_stop: assert property (p_stop) else $error("clock not stopped");
	a_err_on: assert property (p_err_on) else $error("error output missing");
	a_err_off: assert property (p_err_off) else $error("error output spurious");
	a_rdv: assert property (p_rdv) else $error("read answer missing");
	c_err: cover property (!o_primary_system_error_n);
	c_stop: cover property (cw);
	c_rd: cover property (gr);
endmodule
bind bgce_regs bgce_regs_asserts #(.PINS(PINS)) chk_u (.i_mclk, .i_reset_n, .i_cfg_wr,
	.i_cfg_rd, .i_cfg_addr, .i_cfg_byte_en, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rd_valid,
	.o_gpio_out, .o_gpio_oe, .o_secondary_clock_outputs, .i_err_event, .i_event_disable,
	.i_system_error_enable_bit, .o_primary_system_error_n);
`default_nettype wire

// File: sim/bgce_host.sv
`default_nettype none
module bgce_host (
	input wire logic i_mclk,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [3:0] o_be,
	output logic [31:0] o_wdata,
	input wire logic [31:0] i_rdata,
	input wire logic i_rd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{o_wr, o_rd, o_addr, o_be, o_wdata} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
		@(negedge i_mclk);
		{o_wr, o_addr, o_be, o_wdata} = {1'b1, a, b, v};
		@(negedge i_mclk);
		o_wr = 1'b0;
		// released data lines do not keep the last value
		o_wdata = ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(negedge i_mclk);
		{o_rd, o_addr} = {1'b1, a};
		@(negedge i_mclk);
		o_rd = 1'b0;
		v = i_rd_valid ? i_rdata : ~i_rdata;
	endtask
endmodule
`default_nettype wire

// File: sim/tb_bridge_gpio_clkgate_error_regs.sv
`default_nettype none
module tb_bridge_gpio_clkgate_error_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_reset_n, wr, rd, sys_en, rv, err_n;
	logic [7:0] addr, ev, dis;
	logic [3:0] be, ext, out, oe, pin;
	logic [31:0] wd, rdat, d;
	logic [9:0] sck, prev;
	int miscompares, comparisons, cyc;
	// pin wire level: driven value where enabled, outside level elsewhere
	assign pin = (oe & out) | (~oe & ext);
	bgce_host host_u (.i_mclk, .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_be(be),
		.o_wdata(wd), .i_rdata(rdat), .i_rd_valid(rv));
	bgce_regs dut_u (.i_mclk, .i_reset_n, .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
		.i_cfg_byte_en(be), .i_cfg_wdata(wd), .o_cfg_rdata(rdat), .o_cfg_rd_valid(rv),
		.i_gpio_in(pin), .o_gpio_out(out), .o_gpio_oe(oe), .o_secondary_clock_outputs(sck),
		.i_err_event(ev), .i_event_disable(dis), .i_system_error_enable_bit(sys_en),
		.o_primary_system_error_n(err_n));
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic t_reset();
		chk({oe, out, err_n, sck}, {9'h001, 10'h0});
		host_u.rd(8'h64, d);
		chk(d[27:8], 20'h0);
		host_u.rd(8'h68, d);
		chk(d, 32'h0);
		host_u.rd(8'h70, d);
		chk(d, 32'h0);
	endtask
	task automatic t_gpio();
		host_u.wr(8'h64, 4'h4, 32'h0030_0000);
		chk(oe, 4'h3);
		host_u.wr(8'h64, 4'h2, 32'h0000_5000);
		chk(out, 4'h5);
		host_u.wr(8'h64, 4'h4, 32'h0000_f000);
		chk(out, 4'h5);
		repeat (3) @(negedge i_mclk);
		host_u.rd(8'h64, d);
		chk(d[31:8], 24'h900050);
		host_u.wr(8'h64, 4'h6, 32'h0021_0100);
		chk({out, oe}, 8'h42);
		host_u.wr(8'h64, 4'h6, 32'h0);
		chk({out, oe}, 8'h42);
		repeat (3) @(negedge i_mclk);
		host_u.rd(8'h64, d);
		chk(d[31:28], 4'h8);
	endtask
	task automatic t_clk();
		logic [15:0] w [4] = '{16'h0055, 16'h00aa, 16'h3f0f, 16'hffff};
		logic [9:0] m [4] = '{10'h3ff, 10'h3ff, 10'h00c, 10'h000};
		for (int k = 0; k < 4; k++) begin
			host_u.wr(8'h68, 4'h3, {16'h0, w[k]});
			repeat (2) @(negedge i_mclk);
			prev = sck;
			@(negedge i_mclk);
			chk({sck ^ prev, sck & ~m[k]}, {m[k], 10'h0});
		end
		host_u.rd(8'h68, d);
		chk(d[15:0], 16'h3fff);
	endtask
	task automatic t_err();
		sys_en = 1'b1;
		for (int k = 0; k < 8; k++) begin
			ev = 8'h1 << k;
			@(negedge i_mclk);
			ev = 8'h0;
			chk(err_n, 1'b0);
			@(negedge i_mclk);
			chk(err_n, 1'b1);
			host_u.rd(8'h68, d);
			chk(d[23:16], 8'hff >> (7 - k));
		end
		host_u.wr(8'h68, 4'h4, 32'h00a5_0000);
		host_u.rd(8'h68, d);
		chk(d[31:16], 16'h005a);
		host_u.wr(8'h68, 4'h4, 32'h005a_0000);
		{dis, ev} = 16'hffff;
		@(negedge i_mclk);
		{dis, sys_en} = 9'h0;
		chk(err_n, 1'b1);
		@(negedge i_mclk);
		ev = 8'h0;
		chk(err_n, 1'b1);
		host_u.rd(8'h68, d);
		chk(d[31:16], 16'h0);
	endtask
	initial begin
		{i_reset_n, sys_en, ev, dis} = '0;
		ext = 4'ha;
		repeat (3) @(negedge i_mclk);
		i_reset_n = 1'b1;
		t_reset();
		t_gpio();
		t_clk();
		t_err();
		// mid-run reset with pins driven and clocks stopped
		i_reset_n = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_reset_n = 1'b1;
		t_reset();
		report_and_stop();
	end
endmodule
`default_nettype wire
